// ---- rtl/acs_pkg.sv ----
// Constants, types and register map of the conversion sequencer
package acs_pkg;
  // Clock and timing
  localparam int CLK_PERIOD_NS   = 40;
  localparam int PWRUP_CYCLES    = 65536;
  localparam int CONV_RATE_SPS   = 2000;
  localparam int CONV_PERIOD_NS  = 1000000000 / CONV_RATE_SPS;
  localparam int CHAN_RESTART_NS = 513000;
  localparam int RATE_RESTART_NS = 575000;
  localparam int CONV_PERIOD_CYC  = (CONV_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CHAN_RESTART_CYC = (CHAN_RESTART_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RATE_RESTART_CYC = (RATE_RESTART_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W            = 17;

  // Widths
  localparam int ADDR_W   = 8;
  localparam int DATA_W   = 32;
  localparam int RESULT_W = 16;
  localparam int BYTE_W   = 8;
  localparam int CFG_AW   = 4;
  localparam int CFG_REGS = 16;

  // Serial commands
  localparam logic [3:0] OP_WRITE_NIB  = 4'h4;
  localparam logic [6:0] OP_RDATA_HI   = 7'h09;
  localparam logic [6:0] OP_CONTRD_HI  = 7'h0a;
  localparam logic [6:0] OP_STOPRD_HI  = 7'h0b;
  localparam logic [3:0] CFG_CHAN_IDX  = 4'h0;
  localparam logic [3:0] CFG_RATE_IDX  = 4'h3;

  // Register map
  localparam logic [ADDR_W-1:0] OFF_STATUS = 8'h00;
  localparam logic [ADDR_W-1:0] OFF_MASK   = 8'h04;
  localparam logic [ADDR_W-1:0] OFF_RESULT = 8'h08;
  localparam logic [ADDR_W-1:0] OFF_STATE  = 8'h0c;
  localparam logic [1:0]        CFG_PAGE   = 2'h1;

  // Status bits
  localparam int ST_RESULT = 0;
  localparam int ST_SLEEP  = 1;
  localparam int ST_WRITE  = 2;
  localparam int ST_W      = 3;

  typedef struct packed {
    logic sclk;
    logic mosi;
    logic csN;
  } acs_spi_in_t;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wrData;
    logic              wr;
    logic              rd;
  } acs_bus_req_t;

  typedef enum logic [1:0] {PS_CMD, PS_COUNT, PS_DATA, PS_IGNORE} acs_parse_t;
endpackage

// ---- rtl/acs_sequencer.sv ----
// Conversion sequencer and serial link of a multi-channel converter
// Summary of operation
// - For the first power-up count of clocks conversion stays stopped and serial traffic is ignored; the register port still works.
// - Out of reset continuous read is on, so each result shifts out in 16 clocks after ready falls.
// - A register write command is accepted on the input line while a result shifts out.
// - A channel-select write restarts conversion and ready falls after the channel restart time.
// - One block write may replace the first four configuration registers in sequence.
// - With start low the device sleeps when ready falls; a rate write restarts with its own time.
// - The last result stays readable while asleep and shifts out with 16 clocks.
// - A write is opcode plus start address, then count minus one, then consecutive data bytes.
// - A sleep request lets the conversion in progress finish first.
//
// Implementation choices: the placing of the registers and the strobed register port.
`timescale 1ns/1ps
module acs_sequencer #(
  parameter int PWRUP_CNT    = acs_pkg::PWRUP_CYCLES,
  parameter int CONV_PERIOD  = acs_pkg::CONV_PERIOD_CYC,
  parameter int CHAN_RESTART = acs_pkg::CHAN_RESTART_CYC,
  parameter int RATE_RESTART = acs_pkg::RATE_RESTART_CYC
) (
  input  wire logic                           clk,
  input  wire logic                           rst_n,
  input  wire logic                           clkEn,
  input  wire acs_pkg::acs_bus_req_t          busReq,
  output logic        [acs_pkg::DATA_W-1:0]   busRdData,
  input  wire acs_pkg::acs_spi_in_t           spiIn,
  input  wire logic                           startPin,
  input  wire logic   [acs_pkg::RESULT_W-1:0] convSample,
  output logic                                spiMiso,
  output logic                                resultReadyN,
  output logic                                irq
);
  import acs_pkg::*;

  localparam logic [CNT_W-1:0] PWRUP_V   = CNT_W'(PWRUP_CNT);
  localparam logic [CNT_W-1:0] PERIOD_V  = CNT_W'(CONV_PERIOD);
  localparam logic [CNT_W-1:0] CHAN_V    = CNT_W'(CHAN_RESTART);
  localparam logic [CNT_W-1:0] RATE_V    = CNT_W'(RATE_RESTART);
  localparam logic [CNT_W-1:0] CNT_ONE   = 17'h00001;
  localparam logic [CNT_W-1:0] CNT_TWO   = 17'h00002;
  localparam logic [2:0]       LAST_BIT  = 3'h7;
  localparam int               SYNC_N    = 4;
  localparam logic [3:0]       SYNC_IDLE = 4'h3;
  localparam int               PG_HI     = 7;
  localparam int               PG_LO     = 6;
  localparam int               IX_HI     = 5;
  localparam int               IX_LO     = 2;

  //////////////////////////////////////////////////////////////////////////////
  // State
  logic [3:0]             syncA_reg;
  logic [3:0]             syncB_reg;
  logic                   sclkPrev_reg;
  logic [CNT_W-1:0]       pwrCnt_reg;
  logic [CNT_W-1:0]       convCnt_reg;
  logic [CNT_W-1:0]       convCnt_next;
  logic                   asleep_reg;
  logic                   contMode_reg;
  logic [BYTE_W-2:0]      rxShift_reg;
  logic [2:0]             bitCnt_reg;
  logic                   frameStarted_reg;
  logic [RESULT_W-1:0]    txShift_reg;
  logic [RESULT_W-1:0]    txShift_next;
  logic [RESULT_W-1:0]    result_reg;
  acs_parse_t             parse_reg;
  acs_parse_t             parse_next;
  logic [CFG_AW-1:0]      wrAddr_reg;
  logic [CFG_AW-1:0]      wrAddr_next;
  logic [CFG_AW-1:0]      wrLeft_reg;
  logic [CFG_AW-1:0]      wrLeft_next;
  logic [BYTE_W-1:0]      cfgMem [CFG_REGS];
  logic [ST_W-1:0]        status_reg;
  logic [ST_W-1:0]        mask_reg;
  logic                   readyN_next;

  //////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers and edges
  // Pin order: serial clock, data in, frame select, start
  wire [SYNC_N-1:0] pinRaw = {spiIn.sclk, spiIn.mosi, spiIn.csN, startPin};

  // Two flops per pin, reset to idle so no false frame or edge follows reset
  for (genvar g = 0; g < SYNC_N; g++) begin : g_sync
    always_ff @(posedge clk) begin
      if (!rst_n) begin
        syncA_reg[g] <= SYNC_IDLE[g];
        syncB_reg[g] <= SYNC_IDLE[g];
      end else if (clkEn) begin
        syncA_reg[g] <= pinRaw[g];
        syncB_reg[g] <= syncA_reg[g];
      end
    end
  end

  wire       sclkS     = syncB_reg[3];
  wire       mosiS     = syncB_reg[2];
  wire       csNS      = syncB_reg[1];
  wire       startS    = syncB_reg[0];
  wire       pwrDone   = (pwrCnt_reg == PWRUP_V);
  wire       frameOn   = pwrDone & ~csNS;
  wire       sclkRise  = frameOn & sclkS & ~sclkPrev_reg;
  wire       sclkFall  = frameOn & ~sclkS & sclkPrev_reg;
  wire       byteDone  = sclkFall & (bitCnt_reg == LAST_BIT);
  wire [BYTE_W-1:0] rxByte = {rxShift_reg, mosiS};

  //////////////////////////////////////////////////////////////////////////////
  // Command decode
  wire       isWrite   = (rxByte[7:4] == OP_WRITE_NIB);
  wire       isRdOnce  = (rxByte[7:1] == OP_RDATA_HI);
  wire       isContRd  = (rxByte[7:1] == OP_CONTRD_HI);
  wire       isStopRd  = (rxByte[7:1] == OP_STOPRD_HI);
  wire       cmdByte   = byteDone & (parse_reg == PS_CMD);
  wire       cfgWrEn   = byteDone & (parse_reg == PS_DATA);
  wire       wrChan    = cfgWrEn & (wrAddr_reg == CFG_CHAN_IDX);
  wire       wrRate    = cfgWrEn & (wrAddr_reg == CFG_RATE_IDX);
  wire       reloadTx  = cmdByte & isRdOnce;

  //////////////////////////////////////////////////////////////////////////////
  // Conversion timing
  wire       convRun   = pwrDone & ~asleep_reg;
  wire       loadEvt   = convRun & (convCnt_reg == CNT_ONE);
  wire       preLoad   = convRun & (convCnt_reg == CNT_TWO);
  wire       sleepEnt  = loadEvt & ~startS;
  wire       wakeEvt   = asleep_reg & startS;

  always_comb begin
    convCnt_next = convCnt_reg - CNT_ONE;
    if (!pwrDone) begin
      convCnt_next = PERIOD_V;
    end else if (wrChan) begin
      convCnt_next = CHAN_V;
    end else if (wrRate) begin
      convCnt_next = RATE_V;
    end else if (wakeEvt) begin
      convCnt_next = PERIOD_V;
    end else if (asleep_reg) begin
      convCnt_next = convCnt_reg;
    end else if (loadEvt) begin
      convCnt_next = PERIOD_V;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Write command parser
  always_comb begin
    parse_next  = parse_reg;
    wrAddr_next = wrAddr_reg;
    wrLeft_next = wrLeft_reg;
    if (!frameOn) begin
      parse_next = PS_CMD;
    end else if (byteDone) begin
      case (parse_reg)
        PS_CMD: begin
          if (isWrite) begin
            wrAddr_next = rxByte[3:0];
            parse_next  = PS_COUNT;
          end
        end
        PS_COUNT: begin
          wrLeft_next = rxByte[3:0];
          parse_next  = PS_DATA;
        end
        PS_DATA: begin
          wrAddr_next = wrAddr_reg + 4'h1;
          wrLeft_next = wrLeft_reg - 4'h1;
          if (wrLeft_reg == 4'h0) begin
            parse_next = PS_IGNORE;
          end
        end
        PS_IGNORE: begin
          parse_next = PS_IGNORE;                                      // Extra bytes dropped
        end
        default: begin
          parse_next = PS_CMD;
        end
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Output shift and ready line
  always_comb begin
    txShift_next = txShift_reg;
    if (loadEvt && contMode_reg) begin
      txShift_next = convSample;
    end else if (reloadTx) begin
      txShift_next = result_reg;
    end else if (sclkRise) begin
      txShift_next = {txShift_reg[RESULT_W-2:0], 1'b0};
    end
  end

  always_comb begin
    readyN_next = resultReadyN;
    if (loadEvt) begin
      readyN_next = 1'b0;
    end else if (preLoad || (sclkRise && !frameStarted_reg)) begin
      readyN_next = 1'b1;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Register port decode
  function automatic logic regHit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] off);
    return a == off;
  endfunction

  // Status events; a set wins over a clear in the same cycle
  wire            evResult = loadEvt;
  wire            evSleep  = sleepEnt;
  wire            evCfg    = cfgWrEn;
  wire [ST_W-1:0] stSet    = {evCfg, evSleep, evResult};
  wire            hitStat  = regHit(busReq.addr, OFF_STATUS);
  wire            hitMask  = regHit(busReq.addr, OFF_MASK);
  wire            hitRes   = regHit(busReq.addr, OFF_RESULT);
  wire            hitState = regHit(busReq.addr, OFF_STATE);
  wire [3:0]      stateWd  = {pwrDone, contMode_reg, asleep_reg, resultReadyN};
  wire            wrStat  = busReq.wr & hitStat;
  wire            wrMask  = busReq.wr & hitMask;
  wire [ST_W-1:0] stClr   = wrStat ? busReq.wrData[ST_W-1:0] : {ST_W{1'b0}};
  wire [ST_W-1:0] stNext  = (status_reg & ~stClr) | stSet;
  wire [ST_W-1:0] mkNext  = wrMask ? busReq.wrData[ST_W-1:0] : mask_reg;
  // Config registers are read only here and sit one per word
  wire            cfgHit  = (busReq.addr[PG_HI:PG_LO] == CFG_PAGE);
  wire [CFG_AW-1:0] cfgIx = busReq.addr[IX_HI:IX_LO];
  wire            lowByte = (busReq.addr[IX_LO-1:0] == 2'h0);
  wire [DATA_W-1:0] rdMux =
      hitStat             ? DATA_W'(status_reg) :
      hitMask             ? DATA_W'(mask_reg) :
      hitRes              ? DATA_W'(result_reg) :
      hitState            ? DATA_W'(stateWd) :
      (cfgHit && lowByte) ? DATA_W'(cfgMem[cfgIx]) : {DATA_W{1'b0}};

  //////////////////////////////////////////////////////////////////////////////
  // Sequential logic
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      sclkPrev_reg <= 1'b0;
    end else if (clkEn) begin
      sclkPrev_reg <= sclkS;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pwrCnt_reg  <= {CNT_W{1'b0}};
      convCnt_reg <= {CNT_W{1'b0}};
      asleep_reg  <= 1'b0;
    end else if (clkEn) begin
      if (!pwrDone) begin
        pwrCnt_reg <= pwrCnt_reg + CNT_ONE;
      end
      convCnt_reg <= convCnt_next;
      if (sleepEnt) begin
        asleep_reg <= 1'b1;
      end else if (wakeEvt) begin
        asleep_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rxShift_reg      <= 7'h00;
      bitCnt_reg       <= 3'h0;
      frameStarted_reg <= 1'b0;
      parse_reg        <= PS_CMD;
      wrAddr_reg       <= 4'h0;
      wrLeft_reg       <= 4'h0;
      contMode_reg     <= 1'b1;
    end else if (clkEn) begin
      parse_reg  <= parse_next;
      wrAddr_reg <= wrAddr_next;
      wrLeft_reg <= wrLeft_next;
      if (!frameOn) begin
        bitCnt_reg       <= 3'h0;
        frameStarted_reg <= 1'b0;
      end else begin
        if (sclkFall) begin
          rxShift_reg <= rxByte[BYTE_W-2:0];
          bitCnt_reg  <= bitCnt_reg + 3'h1;
        end
        if (sclkRise) begin
          frameStarted_reg <= 1'b1;
        end
      end
      if (cmdByte && isContRd) begin
        contMode_reg <= 1'b1;
      end else if (cmdByte && isStopRd) begin
        contMode_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      txShift_reg  <= 16'h0000;
      result_reg   <= 16'h0000;
      spiMiso      <= 1'b0;
      resultReadyN <= 1'b1;
    end else if (clkEn) begin
      txShift_reg  <= txShift_next;
      resultReadyN <= readyN_next;
      if (loadEvt) begin
        result_reg <= convSample;
      end
      if (sclkRise) begin
        spiMiso <= txShift_reg[RESULT_W-1];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (cfgWrEn && clkEn && rst_n) begin
      cfgMem[wrAddr_reg] <= rxByte;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      status_reg <= {ST_W{1'b0}};
      mask_reg   <= {ST_W{1'b0}};
      irq        <= 1'b0;
      busRdData  <= {DATA_W{1'b0}};
    end else if (clkEn) begin
      status_reg <= stNext;
      mask_reg   <= mkNext;
      irq        <= |(stNext & mkNext);
      busRdData  <= busReq.rd ? rdMux : {DATA_W{1'b0}};
    end
  end
endmodule

// ---- tb/acs_host_model.sv ----
// Host link master driving mode 1 frames
`timescale 1ns/1ps
module acs_host_model (
  output acs_pkg::acs_spi_in_t spiOut,
  input  wire logic            miso
);
  import acs_pkg::*;
  initial spiOut = '{sclk: 1'b0, mosi: 1'b0, csN: 1'b1};
  // MSB first; write bytes go out while the result bits come in, in the same frame
  task automatic xfer(input logic [47:0] tx, input int n, output logic [47:0] rx);
    rx = '0;
    #13;
    spiOut.csN = 1'b0;
    #160;
    for (int i = n - 1; i >= 0; i--) begin
      spiOut.sclk = 1'b1;
      spiOut.mosi = tx[i];
      #160;
      spiOut.sclk = 1'b0;
      #160;
      rx[i] = miso;
    end
    #160;
    spiOut.csN = 1'b1;
    spiOut.mosi = ~spiOut.mosi;
  endtask
endmodule

// ---- tb/acs_sequencer_monitor.sv ----
// Port-level checker of the conversion sequencer
`timescale 1ns/1ps
module acs_sequencer_monitor #(
  parameter int PWRUP_CNT   = acs_pkg::PWRUP_CYCLES,
  parameter int CONV_PERIOD = acs_pkg::CONV_PERIOD_CYC
) (
  input wire logic                        clk,
  input wire logic                        rst_n,
  input wire logic                        clkEn,
  input wire acs_pkg::acs_bus_req_t       busReq,
  input wire logic [acs_pkg::DATA_W-1:0]  busRdData,
  input wire acs_pkg::acs_spi_in_t        spiIn,
  input wire logic                        startPin,
  input wire logic                        spiMiso,
  input wire logic                        resultReadyN,
  input wire logic                        irq
);
  import acs_pkg::*;
  int         pwrCnt;
  int         gap;
  logic       quiet;
  logic       seen;
  logic       asleep;
  logic [2:0] maskSh;
  ////////////////////////////////////////////////////////////////////////////
  // Shadow state: power-up count, ready spacing, sleep, mask
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pwrCnt <= 0;
      gap    <= 0;
      quiet  <= 1'b0;
      seen   <= 1'b0;
      asleep <= 1'b0;
      maskSh <= '0;
    end else begin
      if (clkEn && pwrCnt < PWRUP_CNT) pwrCnt <= pwrCnt + 1;
      gap    <= $fell(resultReadyN) ? 1 : gap + 1;
      quiet  <= $fell(resultReadyN) | (quiet & spiIn.csN & clkEn & ~asleep);
      seen   <= seen | $fell(resultReadyN);
      asleep <= ($fell(resultReadyN) & ~startPin) | (asleep & ~startPin);
      if (clkEn && busReq.wr && busReq.addr == OFF_MASK) maskSh <= busReq.wrData[2:0];
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence frameRise;
    !spiIn.csN && $rose(spiIn.sclk);
  endsequence
  sequence maskOff;
    maskSh == 3'h0 ##1 maskSh == 3'h0;
  endsequence
  a_reset_idle: assert property (disable iff (1'b0) !rst_n |=>
    resultReadyN && !irq && busRdData == '0 && !spiMiso) else $error("outputs not idle in reset");
  a_pwrup_ready: assert property (pwrCnt < PWRUP_CNT |-> resultReadyN)
    else $error("ready low during power-up");
  a_pwrup_miso: assert property (pwrCnt < PWRUP_CNT |-> $stable(spiMiso))
    else $error("serial output moved during power-up");
  a_conv_period: assert property (seen && quiet && $fell(resultReadyN) |-> gap == CONV_PERIOD)
    else $error("result spacing wrong");
  a_ready_rise: assert property (frameRise and !resultReadyN |-> ##[1:6] resultReadyN)
    else $error("ready not released by readout");
  a_ready_hold: assert property (!resultReadyN && spiIn.csN && gap < CONV_PERIOD - 3
    |=> !resultReadyN) else $error("ready released early");
  a_sleep_hold: assert property (asleep |-> !$fell(resultReadyN))
    else $error("new result while asleep");
  a_miso_idle: assert property (spiIn.csN [*6] |-> $stable(spiMiso))
    else $error("serial output moved outside frame");
  a_rd_unmapped: assert property (!busReq.rd || busReq.addr inside {[8'h10:8'h3f]}
    |=> busRdData == '0) else $error("read data not zero");
  a_irq_masked: assert property (maskOff |-> !irq) else $error("interrupt with mask clear");
endmodule
bind acs_sequencer acs_sequencer_monitor #(.PWRUP_CNT(PWRUP_CNT), .CONV_PERIOD(CONV_PERIOD))
  i_mon (.clk(clk), .rst_n(rst_n), .clkEn(clkEn), .busReq(busReq), .busRdData(busRdData),
  .spiIn(spiIn), .startPin(startPin), .spiMiso(spiMiso), .resultReadyN(resultReadyN),
  .irq(irq));

// ---- tb/acs_sequencer_test.sv ----
// Self-checking bench of the conversion sequencer
`timescale 1ns/1ps
module acs_sequencer_test;
  import acs_pkg::*;
  localparam int PWR  = 300;
  localparam int CONV = 500;
  localparam int CHAN = 300;
  localparam int RATE = 340;
  logic                clk;
  logic                rst_n;
  acs_bus_req_t        busReq;
  logic [DATA_W-1:0]   busRdData;
  acs_spi_in_t         spiIn;
  logic                startPin;
  logic [RESULT_W-1:0] convSample;
  logic                spiMiso;
  logic                resultReadyN;
  logic                irq;
  logic [47:0]         rx;
  logic [31:0]         rd;
  int                  n;
  int                  badCount;
  int                  nTests;
  acs_sequencer #(.PWRUP_CNT(PWR), .CONV_PERIOD(CONV), .CHAN_RESTART(CHAN),
    .RATE_RESTART(RATE)) i_dut (.clk(clk), .rst_n(rst_n), .clkEn(1'b1), .busReq(busReq),
    .busRdData(busRdData), .spiIn(spiIn), .startPin(startPin), .convSample(convSample),
    .spiMiso(spiMiso), .resultReadyN(resultReadyN), .irq(irq));
  acs_host_model i_host (.spiOut(spiIn), .miso(spiMiso));
  initial clk = 1'b0;
  always #20 clk = ~clk;
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    nTests++;
    if (got !== exp) begin
      badCount++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chkWin(input int v, input int lo, input int hi);
    nTests++;
    if (v < lo || v > hi) begin
      badCount++;
      $display("ERROR %0t delay %0d outside %0d..%0d", $time, v, lo, hi);
    end
  endtask
  task automatic regWr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    busReq <= '{addr: a, wrData: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    busReq.wr <= 1'b0;
  endtask
  task automatic rdChk(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk);
    busReq <= '{addr: a, wrData: '0, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    busReq.rd <= 1'b0;
    #1;
    rd = busRdData;
    chk(rd, exp);
  endtask
  // Cycles until a fresh falling edge of the ready line
  task automatic waitFall;
    n = 0;
    while (resultReadyN !== 1'b1 && n < 9000) begin
      @(posedge clk);
      #1;
      n++;
    end
    while (resultReadyN !== 1'b0 && n < 9000) begin
      @(posedge clk);
      #1;
      n++;
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task automatic powerupTest;
    rdChk(OFF_STATE, 32'h5);
    rdChk(8'h30, 32'h0);
    i_host.xfer(48'h45005a, 24, rx);
    @(posedge clk);
    convSample <= 16'hc3a5;
    repeat (PWR) @(posedge clk);
    rdChk(OFF_STATE, 32'hd);
    @(posedge clk);
    #1;
    chk(busRdData, 32'h0);
    rdChk(8'h54, 32'h000000xx);
    chk(32'(rd[7:0] === 8'h5a), 32'h0);
  endtask
  task automatic chanTest;
    regWr(OFF_MASK, 32'h4);
    waitFall;
    waitFall;
    chkWin(n, CONV - 1, CONV + 1);
    i_host.xfer(48'h400096, 24, rx);
    chk(32'(rx[23:8]), 32'hc3a5);
    chk(32'(resultReadyN), 32'h1);
    chk(32'(irq), 32'h1);
    waitFall;
    chkWin(n, CHAN - 8, CHAN - 2);
    rdChk(8'h40, 32'h96);
    rdChk(OFF_STATUS, 32'h5);
    regWr(OFF_STATUS, 32'h7);
    rdChk(OFF_STATUS, 32'h0);
    chk(32'(irq), 32'h0);
  endtask
  task automatic sleepTest;
    waitFall;
    i_host.xfer(48'h400311223344, 48, rx);
    @(posedge clk);
    startPin <= 1'b0;
    convSample <= 16'h5a0f;
    waitFall;
    chkWin(n, RATE - 9, RATE - 2);
    @(posedge clk);
    convSample <= 16'hffff;
    for (int i = 0; i < 4; i++) rdChk(8'h40 + 8'(4 * i), 32'(8'h11 * (i + 1)));
    repeat (3 * CONV) @(posedge clk);
    rdChk(OFF_STATE, 32'he);
    rdChk(OFF_STATUS, 32'h7);
    i_host.xfer(48'h0, 16, rx);
    chk(32'(rx[15:0]), 32'h5a0f);
    @(posedge clk);
    startPin <= 1'b1;
  endtask
  task automatic results;
    $display("Checks %0d mismatches %0d", nTests, badCount);
    if (badCount == 0 && nTests > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    rst_n = 1'b0;
    startPin = 1'b1;
    convSample = '0;
    busReq = '0;
    badCount = 0;
    nTests = 0;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    powerupTest;
    chanTest;
    sleepTest;
    results;
  end
  initial begin
    #1000000;
    badCount++;
    $display("ERROR %0t watchdog expired", $time);
    results;
  end
endmodule
